//--- hw/channel3_calibration_regs.sv
// Channel-three offset and gain calibration register bank with checksum.
// Summary of operation
// RULE_01: Offset word bits 23:8 sit in one 16-bit read-write register, reset zero.
// RULE_02: At 1Ah offset bits 7:0 live in 15:8; lower byte reads zero.
// RULE_03: At 1Bh gain bits 23:8 are a read-write field resetting to 8000h.
// RULE_04: At 1Ch gain bits 7:0 live in 15:8, reset zero; lower byte zero.
// RULE_05: Read-only checksum at 3Eh resets to zero; host writes ignored.
// RULE_06: Host writes only zero to reserved word 3Fh; it resets to zero.
// RULE_07: Offset upper register sits at address 19h, reset zero.
// RULE_08: Checksum is recomputed after every change to a covered register.
`timescale 1ns/1ns
`include "ch3_cal_map.svh"
module channel3_calibration_regs
  import ch3_cal_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wr_data,
  output logic [15:0] reg_rd_data,
  output logic reg_rd_valid,
  output logic [23:0] ch3_offset_corr,
  output logic [23:0] ch3_gain_corr
);
  bank_state_type state;
  bank_state_type next_state;

  // Simple rotate-xor fold over the covered words.
  function automatic logic [15:0] fold(input logic [15:0] acc,
                                       input logic [15:0] word);
    fold = {acc[14:0], acc[15]} ^ word;
  endfunction

  always_comb begin
    next_state = state;
    next_state.rd_valid = 1'b0;
    if (reg_wr_en) begin
      case (reg_addr)
        `ADDR_CH3_OFFSET_CAL_HIGH: begin
          next_state.offset_high = reg_wr_data; // see RULE_01 RULE_07
        end
        `ADDR_CH3_OFFSET_CAL_LOW: begin
          next_state.offset_low =
            reg_wr_data[`LOW_FIELD_MSB:`LOW_FIELD_LSB]; // see RULE_02
        end
        `ADDR_CH3_GAIN_CAL_HIGH: begin
          next_state.gain_high = reg_wr_data; // see RULE_03
        end
        `ADDR_CH3_GAIN_CAL_LOW: begin
          next_state.gain_low =
            reg_wr_data[`LOW_FIELD_MSB:`LOW_FIELD_LSB]; // see RULE_04
        end
        `ADDR_RESERVED_ZERO_WORD: begin
          next_state.reserved_word = reg_wr_data; // see RULE_06
        end
        default: begin
          next_state.dirty = state.dirty; // see RULE_05
        end
      endcase
      if (reg_addr != `ADDR_REGISTER_MAP_CHECKSUM) begin
        next_state.dirty = 1'b1;
      end
    end else if (state.dirty) begin
      next_state.checksum = fold(fold(fold(fold(fold(`CHECKSUM_SEED,
        state.offset_high), {state.offset_low, 8'h00}), state.gain_high),
        {state.gain_low, 8'h00}), state.reserved_word); // see RULE_08
      next_state.dirty = 1'b0;
    end
    if (reg_rd_en) begin
      next_state.rd_valid = 1'b1;
      case (reg_addr)
        `ADDR_CH3_OFFSET_CAL_HIGH: next_state.rd_data = state.offset_high;
        `ADDR_CH3_OFFSET_CAL_LOW: begin
          next_state.rd_data = {state.offset_low, 8'h00}; // see RULE_02
        end
        `ADDR_CH3_GAIN_CAL_HIGH: next_state.rd_data = state.gain_high;
        `ADDR_CH3_GAIN_CAL_LOW: begin
          next_state.rd_data = {state.gain_low, 8'h00}; // see RULE_04
        end
        `ADDR_REGISTER_MAP_CHECKSUM: begin
          next_state.rd_data = state.checksum; // see RULE_05
        end
        `ADDR_RESERVED_ZERO_WORD: next_state.rd_data = state.reserved_word;
        default: next_state.rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state.offset_high <= `RST_CH3_OFFSET_CAL_HIGH;
      state.offset_low <= `RST_CH3_OFFSET_CAL_LOW;
      state.gain_high <= `RST_CH3_GAIN_CAL_HIGH;
      state.gain_low <= `RST_CH3_GAIN_CAL_LOW;
      state.reserved_word <= `RST_RESERVED_ZERO_WORD;
      state.checksum <= `RST_REGISTER_MAP_CHECKSUM;
      state.dirty <= 1'b0;
      state.rd_data <= 16'h0000;
      state.rd_valid <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rd_data = state.rd_data;
  assign reg_rd_valid = state.rd_valid;
  assign ch3_offset_corr = {state.offset_high, state.offset_low};
  assign ch3_gain_corr = {state.gain_high, state.gain_low};

  chk_offset_high_write: assert property (@(posedge clk) // see RULE_07
    disable iff (sys_rst)
    reg_wr_en && reg_addr == `ADDR_CH3_OFFSET_CAL_HIGH |=>
    ch3_offset_corr[23:8] == $past(reg_wr_data))
    else $error("offset upper word not stored");

  chk_offset_low_write: assert property (@(posedge clk) // see RULE_02
    disable iff (sys_rst)
    reg_wr_en && reg_addr == `ADDR_CH3_OFFSET_CAL_LOW |=>
    ch3_offset_corr[7:0] ==
    $past(reg_wr_data[`LOW_FIELD_MSB:`LOW_FIELD_LSB]))
    else $error("offset lower byte not stored");

  chk_gain_high_write: assert property (@(posedge clk) // see RULE_03
    disable iff (sys_rst)
    reg_wr_en && reg_addr == `ADDR_CH3_GAIN_CAL_HIGH |=>
    ch3_gain_corr[23:8] == $past(reg_wr_data))
    else $error("gain upper word not stored");

  chk_gain_low_write: assert property (@(posedge clk) // see RULE_04
    disable iff (sys_rst)
    reg_wr_en && reg_addr == `ADDR_CH3_GAIN_CAL_LOW |=>
    ch3_gain_corr[7:0] ==
    $past(reg_wr_data[`LOW_FIELD_MSB:`LOW_FIELD_LSB]))
    else $error("gain lower byte not stored");

  chk_offset_high_read: assert property (@(posedge clk) // see RULE_01
    disable iff (sys_rst)
    reg_rd_en && reg_addr == `ADDR_CH3_OFFSET_CAL_HIGH |=>
    reg_rd_data == $past(ch3_offset_corr[23:8]))
    else $error("offset upper read wrong");

  chk_offset_low_read: assert property (@(posedge clk) // see RULE_02
    disable iff (sys_rst)
    reg_rd_en && reg_addr == `ADDR_CH3_OFFSET_CAL_LOW |=>
    reg_rd_data == {$past(ch3_offset_corr[7:0]), 8'h00})
    else $error("offset lower read wrong");

  chk_gain_high_read: assert property (@(posedge clk) // see RULE_03
    disable iff (sys_rst)
    reg_rd_en && reg_addr == `ADDR_CH3_GAIN_CAL_HIGH |=>
    reg_rd_data == $past(ch3_gain_corr[23:8]))
    else $error("gain upper read wrong");

  chk_gain_low_read: assert property (@(posedge clk) // see RULE_04
    disable iff (sys_rst)
    reg_rd_en && reg_addr == `ADDR_CH3_GAIN_CAL_LOW |=>
    reg_rd_data == {$past(ch3_gain_corr[7:0]), 8'h00})
    else $error("gain lower read wrong");

  chk_checksum_read: assert property (@(posedge clk) // see RULE_05
    disable iff (sys_rst)
    reg_rd_en && reg_addr == `ADDR_REGISTER_MAP_CHECKSUM |=>
    reg_rd_data == $past(state.checksum))
    else $error("checksum read wrong");

  chk_reserved_read: assert property (@(posedge clk) // see RULE_06
    disable iff (sys_rst)
    reg_rd_en && reg_addr == `ADDR_RESERVED_ZERO_WORD |=>
    reg_rd_data == $past(state.reserved_word))
    else $error("reserved word read wrong");

  chk_offset_reset_value: assert property (@(posedge clk) // see RULE_01
    sys_rst |=> ch3_offset_corr ==
    {`RST_CH3_OFFSET_CAL_HIGH, `RST_CH3_OFFSET_CAL_LOW})
    else $error("offset reset value wrong");

  chk_gain_reset_value: assert property (@(posedge clk) // see RULE_03
    sys_rst |=> ch3_gain_corr ==
    {`RST_CH3_GAIN_CAL_HIGH, `RST_CH3_GAIN_CAL_LOW})
    else $error("gain reset value wrong");

  chk_checksum_reset_value: assert property (@(posedge clk) // see RULE_05
    sys_rst |=> state.checksum == `RST_REGISTER_MAP_CHECKSUM)
    else $error("checksum reset value wrong");

  chk_reserved_reset_value: assert property (@(posedge clk) // see RULE_06
    sys_rst |=> state.reserved_word == `RST_RESERVED_ZERO_WORD)
    else $error("reserved word reset value wrong");

  chk_checksum_write_ignored: assert property (@(posedge clk) // see RULE_05
    disable iff (sys_rst)
    reg_wr_en && reg_addr == `ADDR_REGISTER_MAP_CHECKSUM && !state.dirty
    |=> $stable(state.checksum))
    else $error("checksum changed by host write");

  chk_checksum_refresh: assert property (@(posedge clk) // see RULE_08
    disable iff (sys_rst)
    reg_wr_en && reg_addr == `ADDR_CH3_GAIN_CAL_HIGH |=>
    state.dirty ##1 (!state.dirty || $past(reg_wr_en)))
    else $error("checksum not refreshed");

  chk_checksum_hold: assert property (@(posedge clk) // see RULE_08
    disable iff (sys_rst)
    !state.dirty |=> $stable(state.checksum))
    else $error("checksum changed with nothing pending");

  chk_offset_high_hold: assert property (@(posedge clk) // see RULE_01
    disable iff (sys_rst)
    !(reg_wr_en && reg_addr == `ADDR_CH3_OFFSET_CAL_HIGH) |=>
    $stable(ch3_offset_corr[23:8]))
    else $error("offset upper word changed without write");

  chk_offset_low_hold: assert property (@(posedge clk) // see RULE_02
    disable iff (sys_rst)
    !(reg_wr_en && reg_addr == `ADDR_CH3_OFFSET_CAL_LOW) |=>
    $stable(ch3_offset_corr[7:0]))
    else $error("offset lower byte changed without write");

  chk_gain_high_hold: assert property (@(posedge clk) // see RULE_03
    disable iff (sys_rst)
    !(reg_wr_en && reg_addr == `ADDR_CH3_GAIN_CAL_HIGH) |=>
    $stable(ch3_gain_corr[23:8]))
    else $error("gain upper word changed without write");

  chk_gain_low_hold: assert property (@(posedge clk) // see RULE_04
    disable iff (sys_rst)
    !(reg_wr_en && reg_addr == `ADDR_CH3_GAIN_CAL_LOW) |=>
    $stable(ch3_gain_corr[7:0]))
    else $error("gain lower byte changed without write");

  chk_read_latency: assert property (@(posedge clk) // see RULE_01
    disable iff (sys_rst)
    reg_rd_en |=> reg_rd_valid ##1 (reg_rd_valid == $past(reg_rd_en)))
    else $error("read strobe timing wrong");

  chk_read_data_hold: assert property (@(posedge clk) // see RULE_01
    disable iff (sys_rst)
    !reg_rd_en |=> $stable(reg_rd_data))
    else $error("read data changed without read");
endmodule

//--- hw/ch3_cal_map.svh
// Register offsets, reset values and field positions of the calibration bank.
`ifndef CH3_CAL_MAP_SVH
`define CH3_CAL_MAP_SVH
`define ADDR_CH3_OFFSET_CAL_HIGH 6'h19
`define ADDR_CH3_OFFSET_CAL_LOW 6'h1A
`define ADDR_CH3_GAIN_CAL_HIGH 6'h1B
`define ADDR_CH3_GAIN_CAL_LOW 6'h1C
`define ADDR_REGISTER_MAP_CHECKSUM 6'h3E
`define ADDR_RESERVED_ZERO_WORD 6'h3F
`define RST_CH3_OFFSET_CAL_HIGH 16'h0000
`define RST_CH3_OFFSET_CAL_LOW 8'h00
`define RST_CH3_GAIN_CAL_HIGH 16'h8000
`define RST_CH3_GAIN_CAL_LOW 8'h00
`define RST_REGISTER_MAP_CHECKSUM 16'h0000
`define RST_RESERVED_ZERO_WORD 16'h0000
`define LOW_FIELD_MSB 15
`define LOW_FIELD_LSB 8
`define CHECKSUM_SEED 16'hFFFF
`endif

//--- hw/ch3_cal_pkg.sv
// Types shared by the calibration register bank.
package ch3_cal_pkg;
  typedef struct packed {
    logic [15:0] offset_high;
    logic [7:0] offset_low;
    logic [15:0] gain_high;
    logic [7:0] gain_low;
    logic [15:0] reserved_word;
    logic [15:0] checksum;
    logic dirty;
    logic [15:0] rd_data;
    logic rd_valid;
  } bank_state_type;
endpackage

//--- sim/tb_top.sv
// Self-checking bench for the channel-three calibration register bank.
`timescale 1ns/1ns
`define check(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  n_fail++; $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import ch3_cal_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] reg_wr_data = 16'h0000;
  logic [15:0] reg_rd_data;
  logic reg_rd_valid;
  logic [23:0] ch3_offset_corr;
  logic [23:0] ch3_gain_corr;
  logic [15:0] sum_old;
  int n_fail = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  channel3_calibration_regs dut (.clk(clk), .sys_rst(sys_rst),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .ch3_offset_corr(ch3_offset_corr),
    .ch3_gain_corr(ch3_gain_corr));
  // Issues one write strobe and returns just after the taking edge.
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    #1;
  endtask
  // Issues one read strobe and checks the valid pulse and data.
  task automatic rdc(input logic [5:0] a, input logic [15:0] ex);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    `check("read valid", 1'b1, reg_rd_valid)
    `check("read data", ex, reg_rd_data)
  endtask
  task automatic stop_test;
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(6'h19, 16'h0000);
    rdc(6'h1A, 16'h0000);
    rdc(6'h1B, 16'h8000);
    rdc(6'h1C, 16'h0000);
    rdc(6'h3E, 16'h0000);
    rdc(6'h3F, 16'h0000);
    `check("offset out", 24'h00_0000, ch3_offset_corr)
    `check("gain out", 24'h80_0000, ch3_gain_corr)
    wr(6'h19, 16'hA5C3);
    wr(6'h1A, 16'h7E81);
    wr(6'h1B, 16'h1234);
    wr(6'h1C, 16'hFFFF);
    wr(6'h3F, 16'h0000);
    `check("offset out", 24'hA5_C37E, ch3_offset_corr)
    `check("gain out", 24'h12_34FF, ch3_gain_corr)
    rdc(6'h19, 16'hA5C3);
    rdc(6'h1A, 16'h7E00);
    rdc(6'h1B, 16'h1234);
    rdc(6'h1C, 16'hFF00);
    rdc(6'h20, 16'h0000);
    repeat (3) @(posedge clk);
    rdc(6'h3E, 16'hE517);
    sum_old = reg_rd_data;
    wr(6'h3E, 16'h5A5A);
    repeat (3) @(posedge clk);
    rdc(6'h3E, sum_old);
    wr(6'h19, 16'h0001);
    repeat (3) @(posedge clk);
    rdc(6'h3E, 16'hB93D);
    `check("sum moved", 1'b1, reg_rd_data !== sum_old)
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(6'h1B, 16'h8000);
    rdc(6'h19, 16'h0000);
    rdc(6'h3E, 16'h0000);
    `check("offset out", 24'h00_0000, ch3_offset_corr)
    `check("gain out", 24'h80_0000, ch3_gain_corr)
    stop_test();
  end
endmodule
